// [hdl/tsio_port.v]
// Timed serdes I/O port: pins, counter, timestamp, strobes, pin sharing
`timescale 1ns/10ps
`include "tsio_map.vh"
// Functional notes
// (R1) Port width selectable as 1, 4, 8, 16 or 32 bits.
// (R2) Whole port is one direction, input or output.
// (R3) Port drives pins or samples them, optionally waiting a condition.
// (R4) Each core access finishes in one clock cycle.
// (R5) Open-collector: zero pulls low, one leaves pin floating.
// (R6) Open-collector choice applies to the whole port at once.
// (R7) Data moves through a serdes stage and a transfer register.
// (R8) A 16-bit counter times moves between pins and transfer register.
// (R9) Core reads counter anytime and may program a future transfer time.
// (R10) Each transfer captures the counter as a readable timestamp.
// (R11) Enabled link disconnects the port from shared pins.
// (R12) Enabled narrower port takes priority on shared pins.
// (R13) Unshared pins stay with the wider port.
// (R14) Port still transfers full width when pins are taken.
// (R15) Six clock blocks; block 0 is the reference clock.
// (R16) Clock block may use a 1-bit port, optionally divided.
// (R17) Incoming strobe qualifies input; outgoing strobe marks output.
// (R18) After reset the port uses clock block 0.
// (R19) Met conditions go straight to the scheduler as events.
// (R20) Counter steps once per port clock edge and wraps to zero.
// (R21) Timed output waits in transfer register until counter matches.
module tsio_port (
  input  wire                    clk,
  input  wire                    sys_rst,
  input  wire [`TSIO_WIDTH_W-1:0] width_sel,
  input  wire                    dir_out,
  input  wire                    open_coll,
  input  wire [`TSIO_CLKSEL_W-1:0] clk_sel,
  input  wire                    clk_sel_wr,
  input  wire [`TSIO_NCLK*`TSIO_DIV_W-1:0] div_cfg,
  input  wire [`TSIO_NCLK-1:0]   div_use_pin,
  input  wire                    clk_pin_in,
  input  wire [`TSIO_COND_W-1:0] cond_mode,
  input  wire [`TSIO_W-1:0]      cond_value,
  input  wire                    strobe_in_en,
  input  wire                    strobe_in,
  input  wire                    core_out_wr,
  input  wire [`TSIO_W-1:0]      core_out_data,
  input  wire                    core_time_wr,
  input  wire [`TSIO_CNT_W-1:0]  core_time,
  input  wire                    core_in_rd,
  input  wire                    link_en,
  input  wire [`TSIO_W-1:0]      narrow_claim,
  input  wire [`TSIO_W-1:0]      pin_in,
  output wire [`TSIO_W-1:0]      pin_out,
  output wire [`TSIO_W-1:0]      pin_oe_n,
  output reg                     strobe_out,
  output wire                    core_out_ready,
  output wire                    core_in_valid,
  output reg  [`TSIO_W-1:0]      core_in_data,
  output wire [`TSIO_CNT_W-1:0]  port_count,
  output reg  [`TSIO_CNT_W-1:0]  timestamp,
  output reg                     sched_event
);
  // ***************************
  // Pin input synchronisers
  // ***************************
  // Three stages; a change counts once stage 2 and 3 agree
  reg [`TSIO_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_val_q;
  reg [2:0]         clk_s_q, stb_s_q;
  reg               clk_val_q, stb_val_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_q  <= `TSIO_ZERO32;
      pin_s2_q  <= `TSIO_ZERO32;
      pin_s3_q  <= `TSIO_ZERO32;
      pin_val_q <= `TSIO_ZERO32;
      clk_s_q   <= 3'h0;
      stb_s_q   <= 3'h0;
      clk_val_q <= 1'b0;
      stb_val_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_val_q <= (pin_s2_q & pin_s3_q) | (pin_val_q & (pin_s2_q | pin_s3_q));
      clk_s_q <= {clk_s_q[1:0], clk_pin_in};
      stb_s_q <= {stb_s_q[1:0], strobe_in};
      if (clk_s_q[1] == clk_s_q[2]) begin
        clk_val_q <= clk_s_q[2];
      end
      if (stb_s_q[1] == stb_s_q[2]) begin
        stb_val_q <= stb_s_q[2];
      end
    end
  end

  // ***************************
  // Clock block selection
  // ***************************
  wire [`TSIO_NCLK-1:0] ticks;
  tsio_clkblk u_clk (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .src_pin_sync (clk_val_q),
    .div_cfg      (div_cfg),
    .use_pin      (div_use_pin),
    .tick         (ticks)
  );
  reg [`TSIO_CLKSEL_W-1:0] clk_sel_q;
  // Reset attaches the port to the reference block
  always @(posedge clk) begin
    if (sys_rst) begin
      clk_sel_q <= `TSIO_CLK_REF; // R18
    end else if (clk_sel_wr && clk_sel < `TSIO_NCLK) begin
      clk_sel_q <= clk_sel; // R15
    end
  end
  wire port_tick = ticks[clk_sel_q];

  // ***************************
  // Port counter
  // ***************************
  reg [`TSIO_CNT_W-1:0] count_q;
  // Free-running; natural 16-bit overflow gives the wrap
  always @(posedge clk) begin
    if (sys_rst) begin
      count_q <= `TSIO_CNT_ZERO;
    end else if (port_tick) begin
      count_q <= count_q + `TSIO_CNT_ONE; // R20 R8
    end
  end
  assign port_count = count_q; // R9

  // ***************************
  // Width decode
  // ***************************
  reg [5:0]         step;
  reg [`TSIO_W-1:0] wmask;
  always @* begin
    case (width_sel) // R1
      `TSIO_WIDTH_1:  begin step = 6'd1;  wmask = 32'h00000001; end
      `TSIO_WIDTH_4:  begin step = 6'd4;  wmask = 32'h0000000f; end
      `TSIO_WIDTH_8:  begin step = 6'd8;  wmask = 32'h000000ff; end
      `TSIO_WIDTH_16: begin step = 6'd16; wmask = 32'h0000ffff; end
      default:        begin step = 6'd32; wmask = `TSIO_ONES32; end
    endcase
  end
  // Shifts per word; 32-bit port moves a whole word per tick
  wire [5:0] shifts_per_word = (step == 6'd32) ? 6'd1 : (6'd32 / step);

  // ***************************
  // Transfer register and control
  // ***************************
  reg [`TSIO_W-1:0]     xfer_q;
  reg                   xfer_full_q;
  reg                   timed_q;
  reg [`TSIO_CNT_W-1:0] time_q;
  reg [1:0]             state_q;
  reg [5:0]             nshift_q;
  reg                   in_valid_q;
  wire [`TSIO_W-1:0]    sh_q;
  wire                  sh_load = (state_q == `TSIO_ST_IDLE) && dir_out &&
                                  xfer_full_q && (!timed_q || count_q == time_q);
  // Input condition on the sampled port-width value
  wire [`TSIO_W-1:0] samp = pin_val_q & wmask;
  wire cond_met = (cond_mode == `TSIO_COND_NONE) ||
                  (cond_mode == `TSIO_COND_EQ  && samp == (cond_value & wmask)) ||
                  (cond_mode == `TSIO_COND_NEQ && samp != (cond_value & wmask));
  wire stb_ok   = !strobe_in_en || stb_val_q; // R17
  // A new word starts only once the last one was read, so no word is lost
  wire in_shift = !dir_out && port_tick && stb_ok &&
                  (state_q == `TSIO_ST_XFER || (cond_met && !in_valid_q &&
                  (!timed_q || count_q == time_q))); // R3
  wire out_shift = dir_out && port_tick && (state_q == `TSIO_ST_XFER);

  tsio_serdes u_sd (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .load      (sh_load),
    .load_word (xfer_q),
    .shift     (in_shift || out_shift),
    .shift_in  (samp),
    .step      (step),
    .shreg_q   (sh_q)
  );

  // Core accesses are single-cycle; ready/valid are plain levels
  assign core_out_ready = dir_out && !xfer_full_q; // R4
  assign core_in_valid  = in_valid_q;

  // Transfer sequencing for both directions (R7)
  always @(posedge clk) begin
    if (sys_rst) begin
      xfer_q      <= `TSIO_ZERO32;
      xfer_full_q <= 1'b0;
      timed_q     <= 1'b0;
      time_q      <= `TSIO_CNT_ZERO;
      state_q     <= `TSIO_ST_IDLE;
      nshift_q    <= 6'd0;
      in_valid_q  <= 1'b0;
      core_in_data <= `TSIO_ZERO32;
      timestamp   <= `TSIO_CNT_ZERO;
      sched_event <= 1'b0;
      strobe_out  <= 1'b0;
    end else begin
      sched_event <= 1'b0;
      if (core_time_wr) begin
        timed_q <= 1'b1; // R9
        time_q  <= core_time;
      end
      if (core_in_rd) begin
        in_valid_q <= 1'b0;
      end
      if (core_out_wr && core_out_ready) begin
        xfer_q      <= core_out_data; // R21
        xfer_full_q <= 1'b1;
      end
      case (state_q)
        `TSIO_ST_IDLE: begin
          if (sh_load) begin
            xfer_full_q <= 1'b0; // R21
            timed_q     <= 1'b0;
            timestamp   <= count_q; // R10
            state_q     <= `TSIO_ST_XFER;
            nshift_q    <= 6'd0;
            strobe_out  <= 1'b1; // R17
          end else if (in_shift) begin
            timed_q     <= 1'b0;
            timestamp   <= count_q; // R10
            sched_event <= cond_mode != `TSIO_COND_NONE; // R19
            nshift_q    <= 6'd1;
            state_q     <= (shifts_per_word == 6'd1) ? `TSIO_ST_WAIT
                                                     : `TSIO_ST_XFER;
          end
        end
        `TSIO_ST_XFER: begin
          // Strobe stands while a slice is on the pins, drops after the last
          if (out_shift) begin
            nshift_q   <= nshift_q + 6'd1;
            if (nshift_q + 6'd1 == shifts_per_word) begin
              strobe_out <= 1'b0; // R17
              state_q    <= `TSIO_ST_IDLE;
            end
          end else if (in_shift) begin
            nshift_q <= nshift_q + 6'd1;
            if (nshift_q + 6'd1 == shifts_per_word) begin
              state_q <= `TSIO_ST_WAIT;
            end
          end
        end
        `TSIO_ST_WAIT: begin
          // Full word assembled regardless of pin sharing (R14)
          core_in_data <= (step == 6'd32) ? sh_q : sh_q;
          in_valid_q   <= 1'b1;
          sched_event  <= 1'b1; // R19
          state_q      <= `TSIO_ST_IDLE;
        end
        default: state_q <= `TSIO_ST_IDLE;
      endcase
    end
  end

  // ***************************
  // Pin drive and sharing
  // ***************************
  // Low bits of the shift register hold the current output slice
  wire [`TSIO_W-1:0] out_val = sh_q & wmask;
  wire [`TSIO_W-1:0] own     = wmask & ~narrow_claim & {`TSIO_W{!link_en}};
  // Drive when output and owned; open-collector only drives zeros
  genvar b;
  generate
    for (b = 0; b < `TSIO_W; b = b + 1) begin : pin
      wire drv = dir_out && own[b] && (!open_coll || !out_val[b]); // R2 R6
      assign pin_out[b]  = open_coll ? 1'b0 : out_val[b]; // R5
      assign pin_oe_n[b] = !drv; // R11 R12 R13
    end
  endgenerate
endmodule

// [hdl/tsio_map.vh]
// Constants for the timed serdes I/O port
`ifndef TSIO_MAP_VH
`define TSIO_MAP_VH
`define TSIO_W           32
`define TSIO_CNT_W       16
`define TSIO_CNT_MAX     16'hffff
`define TSIO_CNT_ZERO    16'h0000
`define TSIO_CNT_ONE     16'h0001
`define TSIO_NCLK        6
`define TSIO_CLKSEL_W    3
`define TSIO_CLK_REF     3'h0
`define TSIO_DIV_W       8
`define TSIO_DIV_ZERO    8'h00
`define TSIO_DIV_ONE     8'h01
`define TSIO_REF_DIV     4'h0
`define TSIO_WIDTH_W     3
`define TSIO_WIDTH_1     3'h0
`define TSIO_WIDTH_4     3'h1
`define TSIO_WIDTH_8     3'h2
`define TSIO_WIDTH_16    3'h3
`define TSIO_WIDTH_32    3'h4
`define TSIO_COND_W      2
`define TSIO_COND_NONE   2'h0
`define TSIO_COND_EQ     2'h1
`define TSIO_COND_NEQ    2'h2
`define TSIO_ST_IDLE     2'h0
`define TSIO_ST_WAIT     2'h1
`define TSIO_ST_XFER     2'h2
`define TSIO_ZERO32      32'h00000000
`define TSIO_ONES32      32'hffffffff
`endif

// [hdl/tsio_clkblk.v]
// Clock block bank: six edge enables from ref or a divided 1-bit port
`timescale 1ns/10ps
`include "tsio_map.vh"
module tsio_clkblk (
  input  wire                        clk,
  input  wire                        sys_rst,
  input  wire                        src_pin_sync,
  input  wire [`TSIO_NCLK*`TSIO_DIV_W-1:0] div_cfg,
  input  wire [`TSIO_NCLK-1:0]       use_pin,
  output wire [`TSIO_NCLK-1:0]       tick
);
  // Rising edge of the already synchronised clock pin
  reg  src_prev_q;
  wire src_rise = src_pin_sync & ~src_prev_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_pin_sync;
    end
  end

  // *********************************************
  // Per-block divider; block 0 is always ref clock
  // *********************************************
  genvar g;
  generate
    for (g = 0; g < `TSIO_NCLK; g = g + 1) begin : blk
      reg  [`TSIO_DIV_W-1:0] cnt_q;
      reg                    tick_q;
      wire [`TSIO_DIV_W-1:0] div = div_cfg[g*`TSIO_DIV_W +: `TSIO_DIV_W];
      wire                   src = (g == 0) ? 1'b1 :
                                   (use_pin[g] ? src_rise : 1'b1);
      // Divide the chosen source by div+1; block 0 ignores div (R15, R16)
      always @(posedge clk) begin
        if (sys_rst) begin
          cnt_q  <= `TSIO_DIV_ZERO;
          tick_q <= 1'b0;
        end else begin
          tick_q <= 1'b0;
          if (src) begin
            if (g == 0 || cnt_q >= div) begin // R16
              cnt_q  <= `TSIO_DIV_ZERO;
              tick_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + `TSIO_DIV_ONE;
            end
          end
        end
      end
      assign tick[g] = tick_q;
    end
  endgenerate
endmodule

// [hdl/tsio_serdes.v]
// Serializer/deserializer stage of the port buffer
`timescale 1ns/10ps
`include "tsio_map.vh"
module tsio_serdes (
  input  wire                   clk,
  input  wire                   sys_rst,
  input  wire                   load,
  input  wire [`TSIO_W-1:0]     load_word,
  input  wire                   shift,
  input  wire [`TSIO_W-1:0]     shift_in,
  input  wire [5:0]             step,
  output reg  [`TSIO_W-1:0]     shreg_q
);
  // Shift by port width, right-justified like a little-endian stream
  always @(posedge clk) begin
    if (sys_rst) begin
      shreg_q <= `TSIO_ZERO32;
    end else if (load) begin
      shreg_q <= load_word;
    end else if (shift) begin
      shreg_q <= (shreg_q >> step) | (shift_in << (6'd32 - step));
    end
  end
endmodule

// [dv/tsio_pins_model.sv]
// Pin-side model: resolves pin levels and drives data and strobe
`timescale 1ns/10ps
module tsio_pins_model (
  input  wire [31:0] pin_out,
  input  wire [31:0] pin_oe_n,
  input  wire [31:0] ext_val,
  input  wire        ext_en,
  output wire [31:0] pin_lvl,
  output wire        stb
);
  // ****
  // Wire level and strobe
  // ****
  // Released pins take ext_val while ext_en is set, otherwise the pull-up, never a stale value
  assign pin_lvl = (~pin_oe_n & pin_out) |
                   (pin_oe_n & (ext_en ? ext_val : 32'hffffffff));
  // Strobe is high only while data is offered
  assign stb = ext_en;
endmodule

// [dv/tsio_port_chk.sv]
// Assertion checker for the timed serdes port
`timescale 1ns/10ps
module tsio_port_chk (
  input wire        clk,
  input wire        sys_rst,
  input wire        dir_out,
  input wire        open_coll,
  input wire        link_en,
  input wire [31:0] narrow_claim,
  input wire        core_in_rd,
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe_n,
  input wire        strobe_out,
  input wire        core_in_valid,
  input wire [15:0] port_count,
  input wire        sched_event
);
  // ****
  // Pin ownership and direction
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_oc_no_high:
    assert property (open_coll |-> (pin_out & ~pin_oe_n) == 32'h0)
    else $error("open collector pin driven high");
  a_link_off:
    assert property (link_en |-> pin_oe_n == 32'hffffffff)
    else $error("pin driven under link");
  a_claim_yield:
    assert property ((narrow_claim & ~pin_oe_n) == 32'h0)
    else $error("claimed pin still driven");
  a_in_no_drive:
    assert property (!dir_out |-> pin_oe_n == 32'hffffffff)
    else $error("input port drives a pin");
  // ****
  // Counter, strobe and events
  // ****
  // Skip the first edge after reset, where the past value is stale
  a_count_step:
    assert property (!$past(sys_rst) && port_count != $past(port_count)
      |-> port_count == $past(port_count) + 16'h0001)
    else $error("counter jumped");
  a_event_pulse:
    assert property (sched_event |=> !sched_event)
    else $error("event longer than one cycle");
  a_stb_out_only:
    assert property (strobe_out |-> dir_out)
    else $error("strobe on input port");
  a_valid_event:
    assert property ($rose(core_in_valid) |-> sched_event)
    else $error("word without event");
  a_rd_clears:
    assert property (core_in_rd && core_in_valid |=> !core_in_valid)
    else $error("read left valid set");
endmodule
bind tsio_port tsio_port_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .dir_out(dir_out), .open_coll(open_coll),
  .link_en(link_en), .narrow_claim(narrow_claim), .core_in_rd(core_in_rd),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n), .strobe_out(strobe_out),
  .core_in_valid(core_in_valid), .port_count(port_count),
  .sched_event(sched_event));

// [dv/test_timed_serdes_io_port.sv]
// Self-checking bench for the timed serdes I/O port
`timescale 1ns/10ps
module test_timed_serdes_io_port;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [2:0]  width_sel = 3'h2;
  reg         dir_out = 1'b1;
  reg         open_coll = 1'b0;
  reg  [2:0]  clk_sel = 3'h0;
  reg         clk_sel_wr = 1'b0;
  reg  [47:0] div_cfg = 48'h000000030100;
  reg  [1:0]  cond_mode = 2'h0;
  reg  [31:0] cond_value = 32'h0;
  reg         out_wr = 1'b0;
  reg  [31:0] out_data = 32'h0;
  reg         time_wr = 1'b0;
  reg  [15:0] time_val = 16'h0;
  reg         in_rd = 1'b0;
  reg         link_en = 1'b0;
  reg  [31:0] claim = 32'h0;
  reg  [31:0] ext_val = 32'h0;
  reg         ext_en = 1'b0;
  reg  [31:0] p;
  reg  [15:0] c0;
  reg  [15:0] fs;
  wire [31:0] pin_out;
  wire [31:0] pin_oe_n;
  wire [31:0] pin_lvl;
  wire [31:0] in_data;
  wire [15:0] cnt;
  wire [15:0] ts;
  wire        stb_in;
  wire        stb_out;
  wire        out_rdy;
  wire        in_vld;
  wire        evt;
  integer     err_total = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  integer     n;
  // ****
  // Clock, watchdog and instances
  // ****
  always #12.5 clk = ~clk;
  // Whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      test_done;
    end
  end
  tsio_port dut (
    .clk(clk), .sys_rst(sys_rst), .width_sel(width_sel), .dir_out(dir_out),
    .open_coll(open_coll), .clk_sel(clk_sel), .clk_sel_wr(clk_sel_wr),
    .div_cfg(div_cfg), .div_use_pin(6'h00), .clk_pin_in(1'b0),
    .cond_mode(cond_mode), .cond_value(cond_value), .strobe_in_en(1'b1),
    .strobe_in(stb_in), .core_out_wr(out_wr), .core_out_data(out_data),
    .core_time_wr(time_wr), .core_time(time_val), .core_in_rd(in_rd),
    .link_en(link_en), .narrow_claim(claim), .pin_in(pin_lvl),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .strobe_out(stb_out),
    .core_out_ready(out_rdy), .core_in_valid(in_vld),
    .core_in_data(in_data), .port_count(cnt), .timestamp(ts),
    .sched_event(evt));
  tsio_pins_model u_pins (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
    .ext_en(ext_en), .pin_lvl(pin_lvl), .stb(stb_in));
  // ****
  // Tasks
  // ****
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (err_total == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge clk);
  endtask
  task rst;
    begin
      @(posedge clk);
      sys_rst <= 1'b1;
      tick(16);
      sys_rst <= 1'b0;
    end
  endtask
  // Counter advance over 40 cycles on the selected block
  task meas(input [15:0] e);
    begin
      tick(6);
      #1;
      c0 = cnt;
      tick(40);
      #1;
      chk(cnt - c0, e);
    end
  endtask
  task rate(input [2:0] s, input [15:0] e);
    begin
      @(posedge clk);
      clk_sel <= s;
      clk_sel_wr <= 1'b1;
      @(posedge clk);
      clk_sel_wr <= 1'b0;
      meas(e);
    end
  endtask
  // Send one word; slices are seen on the wire low slice first
  task send(input [31:0] w, input [2:0] wc);
    integer wid;
    integer k;
    integer j;
    reg [31:0] m;
    begin
      wid = wc == 3'h0 ? 1 : 4 << (wc - 1);
      m = wid == 32 ? 32'hffffffff : (32'h1 << wid) - 1;
      k = 0;
      width_sel <= wc;
      @(posedge clk);
      out_data <= w;
      out_wr <= 1'b1;
      @(posedge clk);
      out_wr <= 1'b0;
      for (j = 0; j < 400 && k < 32 / wid; j = j + 1) begin
        @(posedge clk);
        #1;
        if (stb_out === 1'b1) begin
          if (k == 0)
            fs = cnt;
          chk(pin_lvl & m, (w >> (k * wid)) & m);
          k = k + 1;
        end
      end
      chk(k, 32 / wid);
      chk((fs - ts) < 16'h3, 1);
      tick(3);
      #1;
      chk(stb_out, 0);
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    tick(2);
    #1;
    chk({ts, in_vld, stb_out, evt}, 32'h0);
    meas(40);
    rate(3'h1, 20);
    rate(3'h6, 20);
    rate(3'h2, 10);
    rst;
    meas(40);
    for (i = 0; i < 5; i = i + 1)
      send(32'h8e1d4b72, i[2:0]);
    open_coll <= 1'b1;
    send(32'h12c3a50f, 3'h2);
    open_coll <= 1'b0;
    // Timed word holds until the counter meets the set value
    @(posedge clk);
    time_val <= cnt + 16'h001e;
    time_wr <= 1'b1;
    @(posedge clk);
    time_wr <= 1'b0;
    send(32'h0000c0de, 3'h3);
    chk((ts - time_val) < 16'h3, 1);
    link_en <= 1'b1;
    tick(1);
    #1;
    chk(pin_oe_n, 32'hffffffff);
    link_en <= 1'b0;
    claim <= 32'h0000000f;
    tick(1);
    #1;
    chk(pin_oe_n[7:0], 8'h0f);
    claim <= 32'h0;
    // Input under each condition mode: blocked value first, except with no condition
    for (i = 0; i < 3; i = i + 1) begin
      rst;
      dir_out <= 1'b0;
      width_sel <= 3'h2;
      cond_mode <= i[1:0];
      cond_value <= 32'h5a;
      ext_val <= i == 1 ? 32'h33 : 32'h5a;
      ext_en <= 1'b1;
      tick(20);
      #1;
      if (i != 0)
        chk(in_vld, 0);
      p = i == 2 ? 32'h33 : 32'h5a;
      ext_val <= p;
      for (n = 0; n < 60 && in_vld !== 1'b1; n = n + 1)
        @(posedge clk);
      ext_en <= 1'b0;
      chk(in_data, {4{p[7:0]}});
      tick(6);
      in_rd <= 1'b1;
      tick(1);
      in_rd <= 1'b0;
      tick(1);
      #1;
      chk(in_vld, 0);
    end
    test_done;
  end
endmodule
